// >>> core/idtic_core.sv
// Isolated DIO card core: digital ports, three down counters, dual interrupt groups
`timescale 1ns/10ps
`default_nettype none

module idtic_core
   import idtic_pkg::*;
(
   // Clock and resets
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              soft_rst,
   // Byte-wide register port from the bus bridge
   input  wire logic [ADDR_W-1:0] bus_addr,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   input  wire logic [7:0]        bus_wdata,
   output logic      [7:0]        bus_rdata,
   // Isolated pins
   input  wire logic [15:0]       isolated_input_channel,
   output logic      [15:0]       isolated_output_channel,
   // Shared interrupt line
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire logic sreset  = !rst_n || soft_rst;
   wire logic wr_dlo  = bus_wr && (bus_addr == OFS_DIO_LO);
   wire logic wr_dhi  = bus_wr && (bus_addr == OFS_DIO_HI);
   wire logic wr_cw   = bus_wr && (bus_addr == OFS_CTRL_WORD);
   wire logic wr_intc = bus_wr && (bus_addr == OFS_INTC);
   wire logic [1:0] cw_sel = bus_wdata[CW_SEL_LSB+:2];
   wire idtic_rw_e  cw_rw  = idtic_rw_e'(bus_wdata[CW_RW_LSB+:2]);
   wire logic [2:0] cw_mode = bus_wdata[CW_MODE_LSB+:3];

   logic [15:0] dout_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  intc_ff;
   logic [1:0]  flag_ff;
   logic        irq_ff;
   logic [25:0] tick_acc_ff;
   logic        tick10_ff;
   logic [2:0]  cout_prev_ff;
   logic        in15_prev_ff;
   logic [5:0]  src_prev_ff;

   ////////////////////////////////////////////////////////////////////////////
   // 10 MHz enable from 25 MHz: 2 ticks every 5 cycles, never adjacent
   wire logic [25:0] tick_sum = tick_acc_ff + TICK_STEP;
   wire logic        tick_hit = tick_sum >= TICK_WRAP;
   wire logic [25:0] nxt_tick_acc = tick_hit ? 26'(tick_sum - TICK_WRAP) : tick_sum;

   always_ff @(posedge sys_clk) begin
      if (sreset) begin
         tick_acc_ff <= '0;
         tick10_ff   <= 1'b0;
      end else begin
         tick_acc_ff <= nxt_tick_acc;
         tick10_ff   <= tick_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counters; gates are absent, so only bus writes to a counter inhibit counting
   idtic_cnt_s cnt_ff [3];
   logic [7:0] cnt_rbyte [3];
   wire logic [2:0] cout = {cnt_ff[2].out, cnt_ff[1].out, cnt_ff[0].out};
   wire logic [2:0] tick;
   assign tick[0] = tick10_ff;
   assign tick[1] = cout[0] && !cout_prev_ff[0];
   assign tick[2] = isolated_input_channel[15] && !in15_prev_ff;

   for (genvar i = 0; i < 3; i++) begin : g_cnt
      localparam logic [ADDR_W-1:0] MY_OFS = 6'(OFS_CNT0 + 6'(i));
      wire logic sel_me  = wr_cw && (cw_sel == 2'(i)) && (cw_sel != CW_READBACK);
      wire logic data_wr = bus_wr && (bus_addr == MY_OFS);
      wire logic data_rd = bus_rd && (bus_addr == MY_OFS);
      wire logic sq      = cnt_ff[i].mode[1:0] == 2'h3;
      wire logic rate    = cnt_ff[i].mode[1:0] == 2'h2;
      wire logic [15:0] rval = cnt_ff[i].latched ? cnt_ff[i].latch : cnt_ff[i].count;
      wire logic hi_byte = (cnt_ff[i].rw == IDTIC_RW_MSB) || ((cnt_ff[i].rw == IDTIC_RW_BOTH) && cnt_ff[i].rd_hi);
      assign cnt_rbyte[i] = hi_byte ? rval[15:8] : rval[7:0];

      always_ff @(posedge sys_clk) begin
         if (sreset) begin
            cnt_ff[i] <= CNT_RST;
         end else begin
            if (sel_me) begin
               if (cw_rw == IDTIC_RW_LATCH) begin
                  if (!cnt_ff[i].latched)
                     cnt_ff[i].latch <= cnt_ff[i].count;
                  cnt_ff[i].latched <= 1'b1;
               end else begin
                  cnt_ff[i].mode      <= cw_mode;
                  cnt_ff[i].rw        <= cw_rw;
                  cnt_ff[i].out       <= cw_mode != 3'h0;
                  cnt_ff[i].armed     <= 1'b0;
                  cnt_ff[i].load_pend <= 1'b0;
                  cnt_ff[i].wr_hi     <= 1'b0;
                  cnt_ff[i].rd_hi     <= 1'b0;
                  cnt_ff[i].latched   <= 1'b0;
               end
            end else if (data_wr) begin
               unique case (cnt_ff[i].rw)
                  IDTIC_RW_LSB: begin
                     cnt_ff[i].reload    <= {8'h00, bus_wdata};
                     cnt_ff[i].load_pend <= 1'b1;
                  end
                  IDTIC_RW_MSB: begin
                     cnt_ff[i].reload    <= {bus_wdata, 8'h00};
                     cnt_ff[i].load_pend <= 1'b1;
                  end
                  IDTIC_RW_BOTH: begin
                     cnt_ff[i].wr_hi <= !cnt_ff[i].wr_hi;
                     if (!cnt_ff[i].wr_hi) begin
                        cnt_ff[i].reload[7:0] <= bus_wdata;
                        // First byte halts a mode 0 count, which otherwise runs past terminal count
                        if (cnt_ff[i].mode == 3'h0)
                           cnt_ff[i].armed <= 1'b0;
                     end else begin
                        cnt_ff[i].reload[15:8] <= bus_wdata;
                        cnt_ff[i].load_pend    <= 1'b1;
                     end
                  end
                  IDTIC_RW_LATCH: begin
                  end
               endcase
               if (cnt_ff[i].mode == 3'h0 && cnt_ff[i].rw != IDTIC_RW_LATCH)
                  cnt_ff[i].out <= 1'b0;
            end else if (tick[i]) begin
               if (cnt_ff[i].load_pend) begin
                  cnt_ff[i].count     <= idtic_start(cnt_ff[i].reload, sq, cnt_ff[i].out);
                  cnt_ff[i].load_pend <= 1'b0;
                  cnt_ff[i].armed     <= 1'b1;
               end else if (cnt_ff[i].armed) begin
                  if (sq) begin
                     // Exact match: odd full-scale reload starts at zero, meaning 65536
                     if (cnt_ff[i].count == 16'h0002) begin
                        cnt_ff[i].out   <= !cnt_ff[i].out;
                        cnt_ff[i].count <= idtic_start(cnt_ff[i].reload, 1'b1, !cnt_ff[i].out);
                     end else begin
                        cnt_ff[i].count <= 16'(cnt_ff[i].count - 16'h0002);
                     end
                  end else if (rate) begin
                     if (cnt_ff[i].count == 16'h0002) begin
                        cnt_ff[i].out   <= 1'b0;
                        cnt_ff[i].count <= 16'h0001;
                     end else if (cnt_ff[i].count == 16'h0001) begin
                        cnt_ff[i].out   <= 1'b1;
                        cnt_ff[i].count <= cnt_ff[i].reload;
                     end else begin
                        cnt_ff[i].count <= 16'(cnt_ff[i].count - 16'h0001);
                     end
                  end else begin
                     // Keeps decrementing past terminal count, output stays high
                     if (cnt_ff[i].count == 16'h0001)
                        cnt_ff[i].out <= 1'b1;
                     cnt_ff[i].count <= 16'(cnt_ff[i].count - 16'h0001);
                  end
               end
            end
            if (data_rd) begin
               if (cnt_ff[i].rw == IDTIC_RW_BOTH)
                  cnt_ff[i].rd_hi <= !cnt_ff[i].rd_hi;
               if (cnt_ff[i].latched && (cnt_ff[i].rw != IDTIC_RW_BOTH || cnt_ff[i].rd_hi))
                  cnt_ff[i].latched <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt groups
   wire logic [5:0] src_now = {cout[2], isolated_input_channel[12], isolated_input_channel[8],
                               cout[1], isolated_input_channel[4], isolated_input_channel[0]};
   wire logic       edge0 = intc_ff[INTC_EDGE0];
   wire logic       edge1 = intc_ff[INTC_EDGE1];
   wire idtic_src_e sel0  = idtic_src_e'(intc_ff[INTC_SEL0_LSB+:2]);
   wire idtic_src_e sel1  = idtic_src_e'(intc_ff[INTC_SEL1_LSB+:2]);
   wire logic [5:0] rise  = src_now & ~src_prev_ff;
   wire logic [5:0] fall  = ~src_now & src_prev_ff;
   wire logic [2:0] ev0   = edge0 ? rise[2:0] : fall[2:0];
   wire logic [2:0] ev1   = edge1 ? rise[5:3] : fall[5:3];
   wire logic hit0 = (sel0 == IDTIC_SRC_A) ? ev0[0] :
                     (sel0 == IDTIC_SRC_AB) ? (ev0[0] || ev0[1]) :
                     (sel0 == IDTIC_SRC_TMR) ? ev0[2] : 1'b0;
   wire logic hit1 = (sel1 == IDTIC_SRC_A) ? ev1[0] :
                     (sel1 == IDTIC_SRC_AB) ? (ev1[0] || ev1[1]) :
                     (sel1 == IDTIC_SRC_TMR) ? ev1[2] : 1'b0;
   wire logic [1:0] clr = {2{wr_intc}} & {bus_wdata[INTC_FLAG1], bus_wdata[INTC_FLAG0]};
   // A new edge wins over a clear in the same cycle
   wire logic [1:0] nxt_flag = {hit1, hit0} | (flag_ff & ~clr);
   wire logic [7:0] intc_rd = {flag_ff[1], intc_ff[6:4], flag_ff[0], intc_ff[2:0]};

   ////////////////////////////////////////////////////////////////////////////
   // Read mux, outputs and register state
   wire logic [7:0] nxt_rdata =
      (bus_addr == OFS_DIO_LO)     ? isolated_input_channel[7:0] :
      (bus_addr == OFS_DIO_HI)     ? isolated_input_channel[15:8] :
      (bus_addr == OFS_CNT0)       ? cnt_rbyte[0] :
      (bus_addr == 6'(OFS_CNT0 + 6'h01)) ? cnt_rbyte[1] :
      (bus_addr == 6'(OFS_CNT0 + 6'h02)) ? cnt_rbyte[2] :
      (bus_addr == OFS_INTC)       ? intc_rd : 8'h00;

   always_ff @(posedge sys_clk) begin
      if (sreset) begin
         dout_ff      <= DOUT_RST;
         rdata_ff     <= 8'h00;
         intc_ff      <= INTC_RST;
         flag_ff      <= 2'h0;
         irq_ff       <= 1'b0;
         cout_prev_ff <= 3'h0;
         in15_prev_ff <= 1'b0;
         src_prev_ff  <= 6'h00;
      end else begin
         if (wr_dlo)
            dout_ff[7:0] <= bus_wdata;
         if (wr_dhi)
            dout_ff[15:8] <= bus_wdata;
         if (bus_rd)
            rdata_ff <= nxt_rdata;
         if (wr_intc)
            intc_ff <= bus_wdata;
         flag_ff      <= nxt_flag;
         irq_ff       <= |nxt_flag;
         cout_prev_ff <= cout;
         in15_prev_ff <= isolated_input_channel[15];
         src_prev_ff  <= src_now;
      end
   end

   assign isolated_output_channel = dout_ff;
   assign bus_rdata               = rdata_ff;
   assign irq                     = irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sreset);

   a_out_reset_low: assert property (disable iff (1'b0) sreset |=> isolated_output_channel == 16'h0000)
      else $error("outputs not low after reset");
   a_dout_write: assert property (wr_dlo |=> isolated_output_channel[7:0] == $past(bus_wdata))
      else $error("output low byte not written");
   a_din_read: assert property (bus_rd && bus_addr == OFS_DIO_LO |=> bus_rdata == $past(isolated_input_channel[7:0]))
      else $error("input low byte read wrong");
   a_tick_spacing: assert property (tick10_ff |=> !tick10_ff ##[1:2] tick10_ff)
      else $error("timer input enable rate wrong");
   a_cascade_clock: assert property ($changed(cnt_ff[1].count) && !$past(bus_wr) |-> $past(tick[1]))
      else $error("second timer moved without first timer output edge");
   a_event_clock: assert property ($changed(cnt_ff[2].count) && !$past(bus_wr) |-> $past(tick[2]))
      else $error("event counter moved without input edge");
   a_grp0_off: assert property (sel0 == IDTIC_SRC_OFF && !flag_ff[0] && !wr_intc |=> !flag_ff[0])
      else $error("disabled group 0 raised flag");
   a_grp1_off: assert property (sel1 == IDTIC_SRC_OFF && !flag_ff[1] && !wr_intc |=> !flag_ff[1])
      else $error("disabled group 1 raised flag");
   a_rise_sets: assert property (sel0 == IDTIC_SRC_A && edge0 && rise[0] |=> flag_ff[0] && irq)
      else $error("rising edge did not set group 0");
   a_fall_sets: assert property (sel1 == IDTIC_SRC_A && !edge1 && fall[3] |=> flag_ff[1] && irq)
      else $error("falling edge did not set group 1");
   a_flag_read: assert property (bus_rd && bus_addr == OFS_INTC |=> bus_rdata[INTC_FLAG0] == $past(flag_ff[0]))
      else $error("flag read wrong");
   a_flag_clear: assert property (wr_intc && bus_wdata[INTC_FLAG0] && !hit0 |=> !flag_ff[0])
      else $error("write one did not clear flag");
   a_flag_keep: assert property (wr_intc && !bus_wdata[INTC_FLAG1] && flag_ff[1] |=> flag_ff[1])
      else $error("write zero cleared flag");
   a_irq_or: assert property (irq == (flag_ff[0] || flag_ff[1]))
      else $error("interrupt line does not follow flags");

   c_grp0_fire: cover property (!flag_ff[0] ##1 flag_ff[0]);
   c_grp1_fire: cover property (!flag_ff[1] ##1 flag_ff[1]);
   c_both_pend: cover property (flag_ff == 2'h3);
   c_cascade:   cover property (tick[1] && cnt_ff[1].armed);

endmodule

`default_nettype wire

// >>> pkg/idtic_pkg.sv
// Constants, types and helpers for the isolated DIO timer and interrupt block
//
// Behaviour
// - Isolated outputs go low after power-on, hardware reset and software reset.
// - Host reads 16 isolated inputs and writes 16 isolated outputs.
// - First two timers chain into one 32-bit timer clocked at 10 MHz.
// - Third counter counts events up to 1 MHz on input channel 15.
// - Gates of all three counters are permanently active.
// - Three 16-bit down counters, the first two chained, accept counts from 2 to 65535.
// - Group 0 uses inputs 0, 4 and timer; group 1 uses 8, 12, counter.
// - Both groups may request together over one shared interrupt line.
// - 8-bit interrupt control register at base plus 32; write controls, read status.
// - Bits 1..0 select, 2 edge, 3 flag for group 0; same at 7..4.
// - Group 0 select: off, input 0, inputs 0 and 4, timer output.
// - Group 1 select: off, input 8, inputs 8 and 12, counter output.
// - Edge bit 1 triggers on rising source edge, 0 on falling edge.
// - Reading a flag returns 1 while that group has an interrupt pending.
// - Writing 1 to a flag clears its pending interrupt; writing 0 does nothing.
// - Counter data ports at base plus 24, 25, 26; control word at 27.
`default_nettype none

package idtic_pkg;

   localparam int unsigned SYS_CLK_HZ = 25_000_000;
   localparam int unsigned TICK_HZ    = 10_000_000;
   localparam int          ADDR_W     = 6;

   // Fractional divider from the system clock to the timer input rate
   localparam logic [25:0] TICK_STEP = 26'(TICK_HZ);
   localparam logic [25:0] TICK_WRAP = 26'(SYS_CLK_HZ);

   localparam logic [ADDR_W-1:0] OFS_DIO_LO    = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_DIO_HI    = 6'h01;
   localparam logic [ADDR_W-1:0] OFS_CNT0      = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_CTRL_WORD = 6'h1B;
   localparam logic [ADDR_W-1:0] OFS_INTC      = 6'h20;

   localparam int INTC_SEL0_LSB = 0;
   localparam int INTC_EDGE0    = 2;
   localparam int INTC_FLAG0    = 3;
   localparam int INTC_SEL1_LSB = 4;
   localparam int INTC_EDGE1    = 6;
   localparam int INTC_FLAG1    = 7;
   localparam int CW_SEL_LSB    = 6;
   localparam int CW_RW_LSB     = 4;
   localparam int CW_MODE_LSB   = 1;

   localparam logic [7:0]  INTC_RST  = 8'h00;
   localparam logic [15:0] DOUT_RST  = 16'h0000;
   localparam logic [1:0]  CW_READBACK = 2'h3;

   typedef enum logic [1:0] {
      IDTIC_SRC_OFF,
      IDTIC_SRC_A,
      IDTIC_SRC_AB,
      IDTIC_SRC_TMR
   } idtic_src_e;

   typedef enum logic [1:0] {
      IDTIC_RW_LATCH,
      IDTIC_RW_LSB,
      IDTIC_RW_MSB,
      IDTIC_RW_BOTH
   } idtic_rw_e;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] reload;
      logic [15:0] latch;
      logic [2:0]  mode;
      idtic_rw_e   rw;
      logic        out;
      logic        armed;
      logic        load_pend;
      logic        wr_hi;
      logic        rd_hi;
      logic        latched;
   } idtic_cnt_s;

   localparam idtic_cnt_s CNT_RST = '0;

   // Odd square-wave counts: high half gets one extra input period
   function automatic logic [15:0] idtic_start(input logic [15:0] reload, input logic sq, input logic hi);
      logic [15:0] v;
      v = reload;
      if (sq && reload[0])
         v = hi ? 16'(reload + 16'h0001) : 16'(reload - 16'h0001);
      return v;
   endfunction

endpackage

`default_nettype wire

// >>> tb/idtic_host_model.sv
// Host-side model issuing byte register cycles through the bus bridge
`timescale 1ns/10ps
`default_nettype none

module idtic_host_model
   import idtic_pkg::*;
(
   // Clock
   input  wire logic              sys_clk,
   // Byte register port towards the device
   output logic      [ADDR_W-1:0] bus_addr,
   output logic                   bus_wr,
   output logic                   bus_rd,
   output logic      [7:0]        bus_wdata
);

   initial begin
      bus_addr  = '0;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
      bus_wdata = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse so stale values never look valid
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      bus_addr  = a;
      bus_wdata = d;
      bus_wr    = 1'b1;
      @(negedge sys_clk);
      bus_wr    = 1'b0;
      bus_addr  = ~a;
      bus_wdata = ~d;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      @(negedge sys_clk);
      bus_addr = a;
      bus_rd   = 1'b1;
      @(negedge sys_clk);
      bus_rd   = 1'b0;
      bus_addr = ~a;
   endtask

   // Mode 3, low byte then high byte of one count
   task automatic load_count(input logic [1:0] idx, input logic [15:0] n);
      wr(OFS_CTRL_WORD, {idx, 2'b11, 3'b011, 1'b0});
      wr(6'(OFS_CNT0 + {4'h0, idx}), n[7:0]);
      wr(6'(OFS_CNT0 + {4'h0, idx}), n[15:8]);
   endtask

endmodule

`default_nettype wire

// >>> tb/isolated_dio_timer_interrupt_ctrl_tb_top.sv
// Self-checking bench for the isolated DIO timer and interrupt block
`timescale 1ns/10ps
`default_nettype none

module isolated_dio_timer_interrupt_ctrl_tb_top;
   import idtic_pkg::*;

   logic              sys_clk;
   logic              rst_n;
   logic              soft_rst;
   logic [15:0]       pins;
   logic [ADDR_W-1:0] bus_addr;
   logic              bus_wr;
   logic              bus_rd;
   logic [7:0]        bus_wdata;
   logic [7:0]        bus_rdata;
   logic [15:0]       dout;
   logic              irq;
   logic              rd_seen;
   logic [15:0]       lfsr;
   logic [8:0]        exp_q[$];
   int                n_mismatch;
   int                checks_done;

   idtic_core u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .soft_rst(soft_rst), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .isolated_input_channel(pins), .isolated_output_channel(dout), .irq(irq));

   idtic_host_model u_host (
      .sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata));

   always #20 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // Note holds {irq, read data} expected one cycle after the read
   task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [8:0] e);
      exp_q.push_back(e);
      u_host.rd(a);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Result monitor
   always @(posedge sys_clk) rd_seen <= bus_rd;

   always @(negedge sys_clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0)
            check({7'h00, irq, bus_rdata}, 16'hFFFF);
         else
            check({7'h00, irq, bus_rdata}, {7'h00, exp_q.pop_front()});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger on the chosen edge, keep the flag on a zero write, clear it on a one write
   task automatic edge_case(input int g, input logic [1:0] sel, input logic e, input int pin);
      logic [7:0] v;
      logic [7:0] f;
      v = 8'({e, sel}) << (4 * g);
      f = (g == 0) ? 8'h08 : 8'h80;
      pins      = '0;
      pins[pin] = ~e;
      idle(3);
      u_host.wr(OFS_INTC, v | f);
      rd_exp(OFS_INTC, {1'b0, v});
      pins[pin] = e;
      idle(3);
      rd_exp(OFS_INTC, {1'b1, v | f});
      pins[pin] = ~e;
      idle(3);
      u_host.wr(OFS_INTC, v);
      rd_exp(OFS_INTC, {1'b1, v | f});
      u_host.wr(OFS_INTC, v | f);
      rd_exp(OFS_INTC, {1'b0, v});
   endtask

   initial begin
      sys_clk     = 1'b0;
      rst_n       = 1'b0;
      soft_rst    = 1'b0;
      pins        = '0;
      n_mismatch  = 0;
      checks_done = 0;
      lfsr        = 16'h005C;
      idle(2);
      rst_n = 1'b1;
      check(dout, 16'h0000);
      rd_exp(OFS_INTC, 9'h000);
      rd_exp(6'h3F, 9'h000);
      rd_exp(OFS_CTRL_WORD, 9'h000);
      // Random inputs read back, outputs written per byte
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         pins = lfsr;
         idle(3);
         rd_exp(OFS_DIO_LO, {1'b0, lfsr[7:0]});
         rd_exp(OFS_DIO_HI, {1'b0, lfsr[15:8]});
         u_host.wr(OFS_DIO_LO, ~lfsr[7:0]);
         u_host.wr(OFS_DIO_HI, lfsr[15:8]);
         check(dout, {lfsr[15:8], ~lfsr[7:0]});
      end
      // Software reset clears outputs and the interrupt register
      u_host.wr(OFS_INTC, 8'h55);
      soft_rst = 1'b1;
      idle(1);
      soft_rst = 1'b0;
      check(dout, 16'h0000);
      pins = '0;
      idle(3);
      rd_exp(OFS_INTC, 9'h000);
      for (int g = 0; g < 2; g++)
         for (int s = 1; s < 3; s++)
            for (int e = 0; e < 2; e++)
               edge_case(g, 2'(s), 1'(e), 8 * g + 4 * (s - 1));
      // Disabled groups never set a flag
      u_host.wr(OFS_INTC, 8'h88);
      pins = 16'h1111;
      idle(3);
      pins = 16'h0000;
      idle(3);
      rd_exp(OFS_INTC, 9'h000);
      // Cascaded timer at minimum count drives group 0
      u_host.load_count(2'd0, 16'h0002);
      u_host.load_count(2'd1, 16'h0002);
      u_host.load_count(2'd2, 16'h0002);
      u_host.wr(OFS_INTC, 8'h0F);
      for (int i = 0; i < 300 && irq !== 1'b1; i++)
         @(negedge sys_clk);
      rd_exp(OFS_INTC, 9'h10F);
      // Event counter on input 15 drives group 1 while group 0 pends
      u_host.wr(OFS_INTC, 8'hF7);
      for (int i = 0; i < 8; i++) begin
         pins[15] = 1'b1;
         idle(2);
         pins[15] = 1'b0;
         idle(2);
      end
      rd_exp(OFS_INTC, 9'h1FF);
      u_host.wr(OFS_INTC, 8'h74);
      u_host.wr(OFS_INTC, 8'h7C);
      rd_exp(OFS_INTC, 9'h1F4);
      u_host.wr(OFS_INTC, 8'h44);
      u_host.wr(OFS_INTC, 8'hC4);
      rd_exp(OFS_INTC, 9'h044);
      // Event counter running past terminal count, low byte only, then a latched read
      u_host.wr(OFS_CTRL_WORD, 8'h90);
      u_host.wr(OFS_INTC, 8'hF4);
      u_host.wr(6'(OFS_CNT0 + 6'h02), 8'h03);
      for (int i = 0; i < 5; i++) begin
         pins[15] = 1'b1;
         idle(2);
         pins[15] = 1'b0;
         idle(2);
      end
      rd_exp(OFS_INTC, 9'h1F4);
      rd_exp(6'(OFS_CNT0 + 6'h02), 9'h1FF);
      u_host.wr(OFS_CTRL_WORD, 8'h80);
      pins[15] = 1'b1;
      idle(2);
      pins[15] = 1'b0;
      idle(2);
      rd_exp(6'(OFS_CNT0 + 6'h02), 9'h1FF);
      rd_exp(6'(OFS_CNT0 + 6'h02), 9'h1FE);
      idle(3);
      check(16'(exp_q.size()), 16'h0000);
      end_of_test();
   end

   // Run needs about 400 cycles
   initial begin
      #800000;
      n_mismatch++;
      end_of_test();
   end

endmodule

`default_nettype wire
